// File: rtl/gbs_pkg.sv
// package for the gyro bias and self-test register bank
package gbs_pkg;

    localparam int          GBS_AW = 7;
    localparam int          GBS_DW = 8;

    // =========================================================
    // register offsets
    localparam logic [6:0] GBS_GYRO_X_ST  = 7'h00;
    localparam logic [6:0] GBS_GYRO_Y_ST  = 7'h01;
    localparam logic [6:0] GBS_GYRO_Z_ST  = 7'h02;
    localparam logic [6:0] GBS_ACCEL_X_ST = 7'h0d;
    localparam logic [6:0] GBS_ACCEL_Y_ST = 7'h0e;
    localparam logic [6:0] GBS_ACCEL_Z_ST = 7'h0f;
    localparam logic [6:0] GBS_GX_BIAS_H  = 7'h13;
    localparam logic [6:0] GBS_GX_BIAS_L  = 7'h14;
    localparam logic [6:0] GBS_GY_BIAS_H  = 7'h15;
    localparam logic [6:0] GBS_GY_BIAS_L  = 7'h16;
    localparam logic [6:0] GBS_GZ_BIAS_H  = 7'h17;
    localparam logic [6:0] GBS_GZ_BIAS_L  = 7'h18;

    // =========================================================
    // reset values and saturation limits
    localparam logic [7:0]  GBS_ZERO_BYTE = 8'h00;
    localparam logic [15:0] GBS_ZERO_WORD = 16'h0000;
    localparam logic [15:0] GBS_SAT_MAX   = 16'h7fff;
    localparam logic [15:0] GBS_SAT_MIN   = 16'h8000;

    // =========================================================
    // carriers
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [7:0]  wdata;
    } gbs_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } gbs_sample_t;

endpackage

// File: rtl/gbs_regs.sv
// gyro bias-offset and self-test reference register bank
// =============================================================
// Notes on behaviour
// - three gyro self-test bytes at 00-02
// - three accel self-test bytes at 0d-0f
// - stored codes come from factory, loaded unchanged
// - x bias high 13, low 14
// - y bias high 15, low 16
// - z bias high byte at 17
// - z bias low byte at 18
// - bias added to raw sample before output
// - self-test bytes reset to factory values
// - bias registers reset to zero
`timescale 1ns/1ps
`default_nettype none

module gbs_regs #(
    parameter logic [7:0] GYRO_X_ST_INIT  = 8'h00,
    parameter logic [7:0] GYRO_Y_ST_INIT  = 8'h00,
    parameter logic [7:0] GYRO_Z_ST_INIT  = 8'h00,
    parameter logic [7:0] ACCEL_X_ST_INIT = 8'h00,
    parameter logic [7:0] ACCEL_Y_ST_INIT = 8'h00,
    parameter logic [7:0] ACCEL_Z_ST_INIT = 8'h00
) (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire gbs_pkg::gbs_req_t   req_in,
    input  wire gbs_pkg::gbs_sample_t raw_in,
    output var  logic [7:0]          rdata_out,
    output var  logic                rvalid_out,
    output var  gbs_pkg::gbs_sample_t gyro_out
);
    import gbs_pkg::*;

    // =========================================================
    // address decode, one hit per register
    wire [6:0] addr_w      = req_in.addr;
    wire       hit_gx_st_w = (addr_w == GBS_GYRO_X_ST);
    wire       hit_gy_st_w = (addr_w == GBS_GYRO_Y_ST);
    wire       hit_gz_st_w = (addr_w == GBS_GYRO_Z_ST);
    wire       hit_ax_st_w = (addr_w == GBS_ACCEL_X_ST);
    wire       hit_ay_st_w = (addr_w == GBS_ACCEL_Y_ST);
    wire       hit_az_st_w = (addr_w == GBS_ACCEL_Z_ST);
    wire       hit_gx_bh_w = (addr_w == GBS_GX_BIAS_H);
    wire       hit_gx_bl_w = (addr_w == GBS_GX_BIAS_L);
    wire       hit_gy_bh_w = (addr_w == GBS_GY_BIAS_H);
    wire       hit_gy_bl_w = (addr_w == GBS_GY_BIAS_L);
    wire       hit_gz_bh_w = (addr_w == GBS_GZ_BIAS_H);
    wire       hit_gz_bl_w = (addr_w == GBS_GZ_BIAS_L);

    // =========================================================
    // write strobes, unmapped writes fall through
    wire       wr_w       = req_in.wr;
    wire       we_gx_st_w = wr_w && hit_gx_st_w;
    wire       we_gy_st_w = wr_w && hit_gy_st_w;
    wire       we_gz_st_w = wr_w && hit_gz_st_w;
    wire       we_ax_st_w = wr_w && hit_ax_st_w;
    wire       we_ay_st_w = wr_w && hit_ay_st_w;
    wire       we_az_st_w = wr_w && hit_az_st_w;
    wire       we_gx_bh_w = wr_w && hit_gx_bh_w;
    wire       we_gx_bl_w = wr_w && hit_gx_bl_w;
    wire       we_gy_bh_w = wr_w && hit_gy_bh_w;
    wire       we_gy_bl_w = wr_w && hit_gy_bl_w;
    wire       we_gz_bh_w = wr_w && hit_gz_bh_w;
    wire       we_gz_bl_w = wr_w && hit_gz_bl_w;

    // =========================================================
    // self-test references, factory values at reset
    wire [7:0] gx_st_w;
    wire [7:0] gy_st_w;
    wire [7:0] gz_st_w;
    wire [7:0] ax_st_w;
    wire [7:0] ay_st_w;
    wire [7:0] az_st_w;

    gbs_byte_reg #(
        .RST_VAL    (GYRO_X_ST_INIT)
    ) u_gx_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gx_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gx_st_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GYRO_Y_ST_INIT)
    ) u_gy_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gy_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gy_st_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GYRO_Z_ST_INIT)
    ) u_gz_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gz_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gz_st_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (ACCEL_X_ST_INIT)
    ) u_ax_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_ax_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (ax_st_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (ACCEL_Y_ST_INIT)
    ) u_ay_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_ay_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (ay_st_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (ACCEL_Z_ST_INIT)
    ) u_az_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_az_st_w),
        .wdata_in   (req_in.wdata),
        .q_out      (az_st_w)
    );

    // =========================================================
    // bias offset bytes, zero at reset
    wire [7:0] gx_bh_w;
    wire [7:0] gx_bl_w;
    wire [7:0] gy_bh_w;
    wire [7:0] gy_bl_w;
    wire [7:0] gz_bh_w;
    wire [7:0] gz_bl_w;

    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gx_bh (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gx_bh_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gx_bh_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gx_bl (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gx_bl_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gx_bl_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gy_bh (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gy_bh_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gy_bh_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gy_bl (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gy_bl_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gy_bl_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gz_bh (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gz_bh_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gz_bh_w)
    );
    gbs_byte_reg #(
        .RST_VAL    (GBS_ZERO_BYTE)
    ) u_gz_bl (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (we_gz_bl_w),
        .wdata_in   (req_in.wdata),
        .q_out      (gz_bl_w)
    );

    // bytes are independent, no shadow copy of the other half
    wire [15:0] gyro_x_bias_value = {gx_bh_w, gx_bl_w};
    wire [15:0] gyro_y_bias_value = {gy_bh_w, gy_bl_w};
    wire [15:0] gyro_z_bias_value = {gz_bh_w, gz_bl_w};

    // =========================================================
    // read select, unmapped reads give zero
    wire [7:0] rd_w =
        ({8{hit_gx_st_w}} & gx_st_w) |
        ({8{hit_gy_st_w}} & gy_st_w) |
        ({8{hit_gz_st_w}} & gz_st_w) |
        ({8{hit_ax_st_w}} & ax_st_w) |
        ({8{hit_ay_st_w}} & ay_st_w) |
        ({8{hit_az_st_w}} & az_st_w) |
        ({8{hit_gx_bh_w}} & gx_bh_w) |
        ({8{hit_gx_bl_w}} & gx_bl_w) |
        ({8{hit_gy_bh_w}} & gy_bh_w) |
        ({8{hit_gy_bl_w}} & gy_bl_w) |
        ({8{hit_gz_bh_w}} & gz_bh_w) |
        ({8{hit_gz_bl_w}} & gz_bl_w);

    // =========================================================
    // read port
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out  <= GBS_ZERO_BYTE;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            if (req_in.rd) begin
                rdata_out <= rd_w;
            end
        end
    end

    // =========================================================
    // biased, saturated sample path
    wire [15:0] sum_x_w;
    wire [15:0] sum_y_w;
    wire [15:0] sum_z_w;

    gbs_sat_add u_sum_x (
        .raw_in     (raw_in.x),
        .bias_in    (gyro_x_bias_value),
        .sum_out    (sum_x_w)
    );
    gbs_sat_add u_sum_y (
        .raw_in     (raw_in.y),
        .bias_in    (gyro_y_bias_value),
        .sum_out    (sum_y_w)
    );
    gbs_sat_add u_sum_z (
        .raw_in     (raw_in.z),
        .bias_in    (gyro_z_bias_value),
        .sum_out    (sum_z_w)
    );

    // =========================================================
    // output sample register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            gyro_out <= '0;
        end else begin
            gyro_out.valid <= raw_in.valid;
            if (raw_in.valid) begin
                gyro_out.x <= sum_x_w;
                gyro_out.y <= sum_y_w;
                gyro_out.z <= sum_z_w;
            end
        end
    end

endmodule

// =============================================================
// one read/write byte with its own reset value
module gbs_byte_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wdata_in,
    output var  logic [7:0] q_out
);
    import gbs_pkg::*;

    logic [7:0] q_reg;
    logic [7:0] q_next;

    assign q_next = wr_en_in ? wdata_in : q_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule

// =============================================================
// signed add of one axis, clamped instead of wrapped
module gbs_sat_add (
    input  wire logic [15:0] raw_in,
    input  wire logic [15:0] bias_in,
    output var  logic [15:0] sum_out
);
    import gbs_pkg::*;

    // a wrap would flip the sign of a large rate
    wire [16:0] wide_w = {raw_in[15], raw_in} + {bias_in[15], bias_in};
    wire        ovf_w  = (wide_w[16] != wide_w[15]);
    wire [15:0] sat_w  = wide_w[16] ? GBS_SAT_MIN : GBS_SAT_MAX;

    assign sum_out = ovf_w ? sat_w : wide_w[15:0];
endmodule

`default_nettype wire

// File: sim/gbs_regs_assertions.sv
// checker on bank ports
`timescale 1ns/1ps
`default_nettype none
module gbs_chk (
    input wire logic                 clk_in,
    input wire logic                 sys_rst_in,
    input wire gbs_pkg::gbs_req_t    req_in,
    input wire gbs_pkg::gbs_sample_t raw_in,
    input wire logic [7:0]           rdata_out,
    input wire logic                 rvalid_out,
    input wire gbs_pkg::gbs_sample_t gyro_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_rv; req_in.rd |=> rvalid_out; endproperty
    a_rv: assert property (p_rv) else $error("rv");
    property p_rq; !req_in.rd |=> !rvalid_out; endproperty
    a_rq: assert property (p_rq) else $error("rq");
    property p_gv; raw_in.valid |=> gyro_out.valid; endproperty
    a_gv: assert property (p_gv) else $error("gv");
    property p_gq; !raw_in.valid |=> !gyro_out.valid; endproperty
    a_gq: assert property (p_gq) else $error("gq");
    property p_rh; !req_in.rd |=> $stable(rdata_out); endproperty
    a_rh: assert property (p_rh) else $error("rh");
    property p_gh; !raw_in.valid |=> $stable(gyro_out.x); endproperty
    a_gh: assert property (p_gh) else $error("gh");
    property p_un; req_in.rd && req_in.addr > 7'h18 |=> !rdata_out; endproperty
    a_un: assert property (p_un) else $error("un");
    property p_wz; req_in.wr && req_in.addr == 7'h18 ##1 !req_in.wr ##1
        req_in.rd && req_in.addr == 7'h18 |=>
        rdata_out == $past(req_in.wdata, 3); endproperty
    a_wz: assert property (p_wz) else $error("wz");
endmodule
`default_nettype wire

// File: sim/testbench.sv
// bench for the bias bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 clk_in = 1'b0, sys_rst_in = 1'b1, rvalid_out, st;
    logic [7:0]           rdata_out;
    gbs_pkg::gbs_req_t    req_in = '0;
    gbs_pkg::gbs_sample_t raw_in = '0, gyro_out;
    int                   fails = 0, tests_run = 0;
    gbs_regs #(.GYRO_X_ST_INIT(8'h21), .ACCEL_Z_ST_INIT(8'h26)) u_dut (
        .clk_in, .sys_rst_in, .req_in, .raw_in, .rdata_out, .rvalid_out,
        .gyro_out);
    always #5 clk_in = ~clk_in;
    task chk(input logic [48:0] s, e);
        tests_run++;
        fails += int'(s !== e);
        if (s !== e) $display("ERROR %0t %h %h", $time, s, e);
    endtask
    task acc(input logic w, logic [6:0] a, logic [7:0] d);
        @(posedge clk_in) req_in <= '{w, !w, a, d};
        @(posedge clk_in) req_in <= '0;
        #1 if (!w) chk(49'({rvalid_out, rdata_out}), 49'({1'b1, d}));
    endtask
    task smp(input logic [47:0] v, e);
        @(posedge clk_in) raw_in <= {1'b1, v};
        @(posedge clk_in) raw_in <= '0;
        #1 chk(gyro_out, {1'b1, e});
    endtask
    task t_reset_values();
        for (int i = 0; i < 27; i++)
            acc(0, 7'(i), i == 0 ? 8'h21 : i == 15 ? 8'h26 : 8'h00);
    endtask
    task t_write_readback();
        for (int i = 0; i < 27; i++) begin
            st = i inside {[0:2], [13:15], [19:24]};
            acc(1, 7'(i), ~8'(i));
            acc(0, 7'(i), st ? ~8'(i) : 8'h00);
        end
    endtask
    task t_bias_sum();
        for (int i = 0; i < 6; i++)
            acc(1, 7'(19 + i), 8'(48'h0010_fff0_8000 >> 8 * (5 - i)));
        smp(48'h7ffa_0005_ffff, 48'h7fff_fff5_8000);
    endtask
    task close_out();
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
        t_write_readback();
        t_bias_sum();
        close_out();
    end
    initial begin
        #20000 fails++;
        close_out();
    end
endmodule
bind gbs_regs gbs_chk u_chk (.clk_in, .sys_rst_in, .req_in, .raw_in,
    .rdata_out, .rvalid_out, .gyro_out);
`default_nettype wire
